// [hdl/hvm_defs.svh]
// register offsets, field positions, codes and reset values of the measurement control
`ifndef HVM_DEFS_SVH
`define HVM_DEFS_SVH

`define HVM_OFS_MODE 8'h00
`define HVM_OFS_MEAS 8'h01
`define HVM_OFS_MP_CFG 8'h02
`define HVM_OFS_PULL 8'h03
`define HVM_OFS_WAKE_CTRL 8'h04
`define HVM_OFS_STAT_FIRST 8'h05
`define HVM_OFS_STAT_SECOND 8'h06
`define HVM_OFS_LVL 8'h07
`define HVM_OFS_STATUS 8'h08

`define HVM_BIT_MEAS 0
`define HVM_BIT_SENSE_WK 0
`define HVM_BIT_FO_TEST 1
`define HVM_BIT_CMD_FAIL 0
`define HVM_BIT_STAT 0

`define HVM_CMD_NORMAL 2'h0
`define HVM_CMD_STOP 2'h1
`define HVM_CMD_SLEEP 2'h2

`define HVM_MP_OFF 3'h0
`define HVM_MP_FAIL_OUT 3'h1
`define HVM_MP_WAKE 3'h2
`define HVM_MP_LOW_SIDE 3'h3
`define HVM_MP_HIGH_SIDE 3'h4

`define HVM_RST_MP_CFG 3'h0
`define HVM_RST_PULL 4'h0
`define HVM_RST_MEAS 1'h0

`endif

// [hdl/hvm_pkg.sv]
// types shared by the measurement control files
package hvm_pkg;

  typedef enum logic [2:0] {
    MODE_NORMAL,
    MODE_STOP,
    MODE_SLEEP,
    MODE_RESTART,
    MODE_FAIL_SAFE
  } hvm_mode_t;

endpackage

// [hdl/hvm_wake_stat.sv]
// wake and level status of both high-voltage pins, gated during measurement
`timescale 1ns/1ps
`include "hvm_defs.svh"

module hvm_wake_stat (
  input wire logic clk,
  input wire logic nrst,
  input wire logic gate,
  input wire logic sense_in,
  input wire logic mp_in,
  input wire logic sense_sense_wake_enable,
  input wire logic mp_sense_wake_enable,
  input wire logic clr_first,
  input wire logic clr_second,
  output logic stat_first,
  output logic stat_second,
  output logic [1:0] lvl,
  output logic wake_evt
);

  // pin edges count only while the pin signals are not gated
  wire set_first = !gate && sense_sense_wake_enable && (sense_in != lvl[0]); // [R6]
  wire set_second = !gate && mp_sense_wake_enable && (mp_in != lvl[1]); // [R6]
  wire [1:0] next_lvl = gate ? lvl : {mp_in, sense_in}; // [R6]

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stat_first <= 1'b0;
      stat_second <= 1'b0;
      lvl <= 2'h0;
      wake_evt <= 1'b0;
    end else begin
      // set wins over a clear in the same cycle
      stat_first <= set_first || (stat_first && !clr_first);
      stat_second <= set_second || (stat_second && !clr_second);
      lvl <= next_lvl;
      wake_evt <= set_first || set_second;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_gate_no_set: assert property (gate |-> !set_first && !set_second) // [R6]
    else $error("wake status set while pins are gated");
  chk_gate_lvl_hold: assert property (gate |=> $stable(lvl)) // [R6]
    else $error("level status changed while pins are gated");

endmodule // hvm_wake_stat

// [hdl/hvm_meas_ctrl.sv]
// high-voltage measurement switch control with mode, pin gating and command checks
`timescale 1ns/1ps
`include "hvm_defs.svh"
// What this block does
// R1: after reset measurement is off, the switch is open and both pins keep their normal roles.
// R2: with measurement disabled both pins work normally and the switch stays open.
// R3: writing one to the enable bit closes the switch, but only in Normal Mode.
// R4: outside Normal Mode the switch opens while the enable bit is kept for the return.
// R5: while measuring, all pull currents of both pins are off whatever their setting.
// R6: while measuring, the pins update neither wake status register nor level status.
// R7: while measuring, pull, wake control and wake enable writes are stored but idle.
// R8: a Sleep command while measuring with only pin wake sources flags failure, goes Restart.
// R9: while measuring the multipurpose pin offers no fail output, test, GPIO or wake.
// R10: while measuring, any change of the multipurpose configuration flags failure.
// R11: enabling is refused with a failure flag unless the multipurpose pin is Off.
// R12: entering Fail-Safe while measuring keeps the enable and holds the switch open.
// R13: entering Fail-Safe without measuring makes the sense pin a wake source.
// R14: the switch equals the enable bit AND Normal Mode, changing on the mode edge.

module hvm_meas_ctrl
  import hvm_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata,
  input wire logic sense_in,
  input wire logic mp_in,
  input wire logic other_wake_src,
  input wire logic fail_safe_evt,
  input wire logic restart_done,
  output logic meas_switch,
  output logic sense_pull_up,
  output logic sense_pull_dn,
  output logic mp_pull_up,
  output logic mp_pull_dn,
  output logic mp_out,
  output logic mp_oe,
  output logic restart_req,
  output logic cmd_fail
);

  if (ADDR_W < 4 || ADDR_W > 16 || DATA_W < 8) begin : g_bad_width
    $error("hvm_meas_ctrl: ADDR_W must be 4..16 and DATA_W at least 8");
  end

  hvm_mode_t mode;
  hvm_mode_t next_mode;
  logic meas_en;
  logic [2:0] mp_cfg;
  logic [3:0] pull_cfg;
  logic sense_sense_wake_enable;
  logic fo_test;
  logic stat_first;
  logic stat_second;
  logic [1:0] lvl;
  logic wake_evt;

  // address decode
  wire hit_mode = addr == ADDR_W'(`HVM_OFS_MODE);
  wire hit_meas = addr == ADDR_W'(`HVM_OFS_MEAS);
  wire hit_mp = addr == ADDR_W'(`HVM_OFS_MP_CFG);
  wire hit_pull = addr == ADDR_W'(`HVM_OFS_PULL);
  wire hit_wkc = addr == ADDR_W'(`HVM_OFS_WAKE_CTRL);
  wire hit_st1 = addr == ADDR_W'(`HVM_OFS_STAT_FIRST);
  wire hit_st2 = addr == ADDR_W'(`HVM_OFS_STAT_SECOND);
  wire hit_lvl = addr == ADDR_W'(`HVM_OFS_LVL);
  wire hit_stat = addr == ADDR_W'(`HVM_OFS_STATUS);

  wire wr_mode = wr && hit_mode;
  wire wr_meas = wr && hit_meas;
  wire wr_mp = wr && hit_mp;
  wire wr_pull = wr && hit_pull;
  wire wr_wkc = wr && hit_wkc;
  wire wr_stat = wr && hit_stat;
  wire clr_first = wr && hit_st1 && wdata[`HVM_BIT_STAT];
  wire clr_second = wr && hit_st2 && wdata[`HVM_BIT_STAT];

  // mode commands are taken only in Normal and Stop
  wire [1:0] cmd = wdata[1:0];
  wire cmd_ok = mode == MODE_NORMAL || mode == MODE_STOP;
  wire sleep_cmd = wr_mode && cmd_ok && cmd == `HVM_CMD_SLEEP;
  wire sleep_blocked = sleep_cmd && meas_en && !other_wake_src; // [R8]
  wire wake_exit = wake_evt && (mode == MODE_SLEEP || mode == MODE_FAIL_SAFE);
  wire fs_entry = fail_safe_evt && mode != MODE_FAIL_SAFE;

  // enable requests refused unless the multipurpose pin is Off
  wire meas_req = wr_meas && wdata[`HVM_BIT_MEAS];
  wire meas_refused = meas_req && !meas_en && mp_cfg != `HVM_MP_OFF; // [R11]
  wire next_meas_en = wr_meas ? (meas_req && !meas_refused) : meas_en; // [R1] [R4] [R12]

  // multipurpose configuration is frozen while measuring
  wire [2:0] mp_wr_val = wdata[2:0];
  wire mp_code_bad = mp_wr_val > `HVM_MP_HIGH_SIDE;
  wire mp_blocked = wr_mp && meas_en && mp_wr_val != mp_cfg; // [R10]
  wire mp_take = wr_mp && !meas_en && !mp_code_bad;
  wire [2:0] next_mp_cfg = mp_take ? mp_wr_val : mp_cfg;

  wire fail_evt = sleep_blocked || meas_refused || mp_blocked || (wr_mp && mp_code_bad);
  wire next_cmd_fail = fail_evt || (cmd_fail && !(wr_stat && wdata[`HVM_BIT_CMD_FAIL]));

  // pull and wake settings are stored even while measuring, used only when not measuring
  wire [3:0] next_pull_cfg = wr_pull ? wdata[3:0] : pull_cfg; // [R7]
  wire next_fo_test = wr_wkc ? wdata[`HVM_BIT_FO_TEST] : fo_test; // [R7]
  wire next_sense_sense_wake_enable = (fs_entry && !meas_en) ? 1'b1 : // [R13]
                          wr_wkc ? wdata[`HVM_BIT_SENSE_WK] : sense_sense_wake_enable; // [R7]

  always_comb begin
    next_mode = mode;
    if (fail_safe_evt) begin
      next_mode = MODE_FAIL_SAFE;
    end else if (sleep_blocked || wake_exit) begin
      next_mode = MODE_RESTART; // [R8]
    end else if (restart_done && mode == MODE_RESTART) begin
      next_mode = MODE_NORMAL;
    end else if (wr_mode && cmd_ok) begin
      case (cmd)
        `HVM_CMD_NORMAL: next_mode = MODE_NORMAL;
        `HVM_CMD_STOP: next_mode = MODE_STOP;
        `HVM_CMD_SLEEP: next_mode = MODE_SLEEP;
        default: next_mode = mode;
      endcase
    end
  end

  // switch follows enable and Normal Mode on the same edge as the mode
  wire next_switch = next_meas_en && next_mode == MODE_NORMAL; // [R2] [R3] [R4] [R12] [R14]

  // pull currents forced off while measuring
  wire [3:0] next_pulls = next_meas_en ? 4'h0 : next_pull_cfg; // [R5] [R7]

  // multipurpose pin functions released while measuring
  wire fo_active = next_mp_cfg == `HVM_MP_FAIL_OUT && (next_mode == MODE_FAIL_SAFE || next_fo_test);
  wire gpio_drive = next_mp_cfg == `HVM_MP_LOW_SIDE || next_mp_cfg == `HVM_MP_HIGH_SIDE;
  wire next_mp_oe = !next_meas_en && (fo_active || gpio_drive); // [R9] [R2]
  wire next_mp_out = !next_meas_en && next_mp_cfg == `HVM_MP_HIGH_SIDE; // [R9]
  wire mp_sense_wake_enable = !meas_en && mp_cfg == `HVM_MP_WAKE; // [R9]
  wire sense_wk_eff = !meas_en && sense_sense_wake_enable; // [R7]

  // read data source
  wire [DATA_W-1:0] rd_val =
    hit_mode ? DATA_W'(mode) :
    hit_meas ? DATA_W'(meas_en) :
    hit_mp ? DATA_W'(mp_cfg) :
    hit_pull ? DATA_W'(pull_cfg) :
    hit_wkc ? DATA_W'({fo_test, sense_sense_wake_enable}) :
    hit_st1 ? DATA_W'(stat_first) :
    hit_st2 ? DATA_W'(stat_second) :
    hit_lvl ? DATA_W'(lvl) :
    hit_stat ? DATA_W'(cmd_fail) : '0;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode <= MODE_NORMAL;
      meas_en <= `HVM_RST_MEAS; // [R1]
      mp_cfg <= `HVM_RST_MP_CFG;
      pull_cfg <= `HVM_RST_PULL;
      sense_sense_wake_enable <= 1'b0;
      fo_test <= 1'b0;
      cmd_fail <= 1'b0;
    end else begin
      mode <= next_mode;
      meas_en <= next_meas_en;
      mp_cfg <= next_mp_cfg;
      pull_cfg <= next_pull_cfg;
      sense_sense_wake_enable <= next_sense_sense_wake_enable;
      fo_test <= next_fo_test;
      cmd_fail <= next_cmd_fail; // [R8] [R10] [R11]
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meas_switch <= 1'b0; // [R1]
      {sense_pull_up, sense_pull_dn, mp_pull_up, mp_pull_dn} <= 4'h0;
      mp_out <= 1'b0;
      mp_oe <= 1'b0;
      restart_req <= 1'b0;
      rdata <= '0;
    end else begin
      meas_switch <= next_switch; // [R14]
      {mp_pull_dn, mp_pull_up, sense_pull_dn, sense_pull_up} <= next_pulls; // [R5]
      mp_out <= next_mp_out;
      mp_oe <= next_mp_oe;
      restart_req <= next_mode == MODE_RESTART && mode != MODE_RESTART;
      rdata <= rd ? rd_val : '0;
    end
  end

  hvm_wake_stat u_stat (
    .clk(clk),
    .nrst(nrst),
    .gate(meas_en), // [R6]
    .sense_in(sense_in),
    .mp_in(mp_in),
    .sense_sense_wake_enable(sense_wk_eff),
    .mp_sense_wake_enable(mp_sense_wake_enable),
    .clr_first(clr_first),
    .clr_second(clr_second),
    .stat_first(stat_first),
    .stat_second(stat_second),
    .lvl(lvl),
    .wake_evt(wake_evt)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_switch_and_mode: assert property (meas_switch == (meas_en && mode == MODE_NORMAL)) // [R14]
    else $error("switch differs from enable and Normal Mode");
  chk_switch_off_idle: assert property (!meas_en |-> !meas_switch && !$rose(meas_switch)) // [R2]
    else $error("switch closed with measurement disabled");
  chk_switch_closes: assert property (
    wr_meas && wdata[`HVM_BIT_MEAS] && mp_cfg == `HVM_MP_OFF && mode == MODE_NORMAL
    && !fail_safe_evt |=> meas_switch ##1 (meas_switch || !meas_en || mode != MODE_NORMAL)) // [R3]
    else $error("switch did not close on enable in Normal Mode");
  chk_open_other_mode: assert property (
    meas_en && mode == MODE_NORMAL && wr_mode && cmd == `HVM_CMD_STOP && !fail_safe_evt
    |=> !meas_switch && meas_en) // [R4]
    else $error("switch not opened or enable lost on leaving Normal Mode");
  chk_fs_keeps_meas: assert property (
    meas_en && fail_safe_evt && !wr_meas |=> meas_en && !meas_switch && mode == MODE_FAIL_SAFE)
    // [R12]
    else $error("fail-safe entry lost enable or left switch closed");
  chk_pulls_off: assert property (
    meas_en |-> {sense_pull_up, sense_pull_dn, mp_pull_up, mp_pull_dn} == 4'h0) // [R5]
    else $error("pull current on while measuring");
  chk_pull_stored: assert property (meas_en && wr_pull |=> pull_cfg == $past(wdata[3:0])) // [R7]
    else $error("pull setting not stored while measuring");
  chk_sleep_blocked: assert property (sleep_blocked && !fail_safe_evt
    |=> mode == MODE_RESTART && cmd_fail && restart_req) // [R8]
    else $error("blocked sleep did not flag failure and restart");
  chk_mp_released: assert property (meas_en |-> !mp_oe && !mp_out) // [R9]
    else $error("multipurpose pin driven while measuring");
  chk_mp_cfg_lock: assert property (
    meas_en && wr_mp && mp_wr_val != mp_cfg |=> cmd_fail && $stable(mp_cfg)) // [R10]
    else $error("multipurpose change while measuring not refused");
  chk_meas_refused: assert property (
    wr_meas && wdata[`HVM_BIT_MEAS] && !meas_en && mp_cfg != `HVM_MP_OFF
    |=> !meas_en && cmd_fail && !meas_switch) // [R11]
    else $error("enable accepted while multipurpose pin not Off");
  chk_fs_sense_wake: assert property (fs_entry && !meas_en && !wr_wkc |=> sense_sense_wake_enable) // [R13]
    else $error("sense pin not made wake source on fail-safe entry");
  chk_rdata_once: assert property (!rd |=> rdata == '0)
    else $error("read data present without a read");

  // restart request is a single pulse on entry only
  chk_restart_pulse: assert property (restart_req |=> !restart_req) // [R8]
    else $error("restart request longer than one cycle");
  chk_restart_entry: assert property (restart_req |-> mode == MODE_RESTART) // [R8]
    else $error("restart request outside Restart Mode");

  // default pin behaviour while not measuring
  chk_pulls_follow: assert property ( // [R2]
    !meas_en |-> {mp_pull_dn, mp_pull_up, sense_pull_dn, sense_pull_up} == pull_cfg)
    else $error("pull currents differ from their setting while not measuring");
  chk_mp_high_side: assert property ( // [R2]
    !meas_en && mp_cfg == `HVM_MP_HIGH_SIDE |-> mp_out && mp_oe)
    else $error("high side drive missing while not measuring");
  chk_mp_off_quiet: assert property (mp_cfg == `HVM_MP_OFF |-> !mp_oe) // [R2]
    else $error("multipurpose pin driven while configured Off");

  // sleep with another wake source is taken, switch opens, enable kept
  chk_sleep_allowed: assert property ( // [R4]
    wr_mode && cmd_ok && cmd == `HVM_CMD_SLEEP && meas_en && other_wake_src
    && !fail_safe_evt |=> mode == MODE_SLEEP && !meas_switch && meas_en)
    else $error("sleep with other wake source not taken or switch left closed");
  chk_meas_kept: assert property (meas_en && !wr_meas |=> meas_en) // [R4]
    else $error("enable lost without a write");
  chk_fs_switch_open: assert property (mode == MODE_FAIL_SAFE |-> !meas_switch) // [R12]
    else $error("switch closed in Fail-Safe Mode");

  // pin wake paths idle while measuring
  chk_wake_idle: assert property (meas_en |-> !mp_sense_wake_enable && !sense_wk_eff) // [R9]
    else $error("pin wake path active while measuring");

  // unchanged configuration write and flag clear behave quietly
  chk_mp_same_ok: assert property ( // [R10]
    meas_en && wr_mp && mp_wr_val == mp_cfg && !cmd_fail |=> !cmd_fail)
    else $error("rewrite of the same multipurpose setting flagged failure");
  chk_fail_clear: assert property ( // [R11]
    wr_stat && wdata[`HVM_BIT_CMD_FAIL] |=> !cmd_fail)
    else $error("command-fail flag not cleared");

  cov_switch_closed: cover property (!meas_switch ##1 meas_switch);
  cov_sleep_blocked: cover property (sleep_blocked);
  cov_fs_measuring: cover property (meas_en && fs_entry);
  cov_enable_refused: cover property (meas_refused);
  cov_sleep_measuring: cover property (meas_en && mode == MODE_SLEEP);

endmodule // hvm_meas_ctrl

// [dv/hvm_pin_model.sv]
// pin side model: hv sense source, multipurpose pin load and measurement switch
`timescale 1ns/1ps

module hvm_pin_model (
  input wire logic sense_lvl,
  input wire logic mp_lvl,
  input wire logic meas_switch,
  input wire logic mp_out,
  input wire logic mp_oe,
  output logic sense_in,
  output logic mp_in
);
  // closed switch ties the multipurpose pin to the sense source
  assign sense_in = sense_lvl;
  assign mp_in = meas_switch ? sense_lvl : (mp_oe ? mp_out : mp_lvl);
endmodule // hvm_pin_model

// [dv/hv_measure_switch_control_tb.sv]
// self-checking bench of the measurement switch control against an integer model
`timescale 1ns/1ps

`define CHK(got, exp) begin \
  compares++; \
  if ((got) !== (exp)) begin \
    err_total++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp); \
  end \
end

module hv_measure_switch_control_tb;
  import hvm_pkg::*;
  logic clk, nrst, wr, rd, sense_lvl, mp_lvl, other_wake_src, fail_safe_evt, restart_done;
  logic [7:0] addr, wdata, rdata, rv;
  logic sense_in, mp_in, meas_switch, sense_pull_up, sense_pull_dn, mp_pull_up, mp_pull_dn;
  logic mp_out, mp_oe, restart_req, cmd_fail;
  int err_total, compares, m_meas, m_mp, m_pull, m_mode, m_fail, m_test, m_rreq;

  hvm_meas_ctrl #(.ADDR_W(8), .DATA_W(8)) dut_u (.clk(clk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sense_in(sense_in), .mp_in(mp_in),
    .other_wake_src(other_wake_src), .fail_safe_evt(fail_safe_evt),
    .restart_done(restart_done), .meas_switch(meas_switch), .sense_pull_up(sense_pull_up),
    .sense_pull_dn(sense_pull_dn), .mp_pull_up(mp_pull_up), .mp_pull_dn(mp_pull_dn),
    .mp_out(mp_out), .mp_oe(mp_oe), .restart_req(restart_req), .cmd_fail(cmd_fail));

  hvm_pin_model pin_u (.sense_lvl(sense_lvl), .mp_lvl(mp_lvl), .meas_switch(meas_switch),
    .mp_out(mp_out), .mp_oe(mp_oe), .sense_in(sense_in), .mp_in(mp_in));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic finish_test;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk_outs;
    logic en;
    @(negedge clk);
    en = (m_meas == 0);
    `CHK(meas_switch, 1'(m_meas == 1 && m_mode == 0))
    `CHK({mp_pull_dn, mp_pull_up, sense_pull_dn, sense_pull_up}, 4'(en ? m_pull : 0))
    `CHK(mp_oe, 1'(en && (m_mp == 3 || m_mp == 4 || (m_mp == 1 && m_test == 1))))
    `CHK(mp_out, 1'(en && m_mp == 4))
    `CHK(cmd_fail, 1'(m_fail))
    `CHK(restart_req, 1'(m_rreq))
    m_rreq = 0;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    `CHK(rdata, exp)
  endtask

  // bus write plus the model's view of its effect
  task automatic mwr(input logic [7:0] a, input logic [7:0] d);
    wreg(a, d);
    case (a)
      8'h00: if (m_mode < 2) begin
        if (d[1:0] == 2 && m_meas == 1 && other_wake_src == 0) begin
          m_mode = 3;
          m_fail = 1;
          m_rreq = 1;
        end else m_mode = d[1:0];
      end
      8'h01: if (d[0] && m_meas == 0 && m_mp != 0) m_fail = 1; else m_meas = d[0];
      8'h02: if (m_meas == 1 && d[2:0] != m_mp) m_fail = 1; else m_mp = d[2:0];
      8'h03: m_pull = d[3:0];
      8'h04: m_test = d[1];
      8'h08: if (d[0]) m_fail = 0;
      default: ;
    endcase
    chk_outs();
  endtask

  task automatic pulse(input int which);
    @(posedge clk);
    if (which == 0) fail_safe_evt <= 1'b1; else restart_done <= 1'b1;
    @(posedge clk);
    fail_safe_evt <= 1'b0;
    restart_done <= 1'b0;
  endtask

  task automatic do_reset;
    nrst <= 1'b0;
    {m_meas, m_mp, m_pull, m_mode, m_fail, m_test, m_rreq} = '0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
  endtask

  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    finish_test();
  end

  initial begin
    {nrst, wr, rd, sense_lvl, mp_lvl, other_wake_src, fail_safe_evt, restart_done} <= '0;
    addr <= 8'h00;
    wdata <= 8'h00;
    err_total = 0;
    compares = 0;
    void'($urandom(32'h66F09452));
    do_reset();
    chk_outs();
    rreg(8'h01, 8'h00);
    mwr(8'h02, 8'h01);
    mwr(8'h04, 8'h02);
    mwr(8'h01, 8'h01);
    rreg(8'h01, 8'h00);
    mwr(8'h08, 8'h01);
    mwr(8'h04, 8'h01);
    mwr(8'h02, 8'h00);
    rv = 8'($urandom_range(1, 15));
    mwr(8'h03, rv);
    mwr(8'h01, 8'h01);
    mwr(8'h03, ~rv & 8'h0F);
    rreg(8'h03, 8'(m_pull));
    mwr(8'h02, 8'h03);
    rreg(8'h02, 8'h00);
    mwr(8'h08, 8'h01);
    mwr(8'h02, 8'h00);
    mwr(8'h04, 8'h03);
    @(posedge clk);
    sense_lvl <= 1'b1;
    mp_lvl <= 1'b1;
    repeat (3) @(posedge clk);
    rreg(8'h05, 8'h00);
    rreg(8'h06, 8'h00);
    rreg(8'h07, 8'h00);
    mwr(8'h00, 8'h01);
    rreg(8'h01, 8'h01);
    mwr(8'h00, 8'h00);
    mwr(8'h00, 8'h02);
    rreg(8'h00, 8'h03);
    pulse(1);
    m_mode = 0;
    chk_outs();
    other_wake_src <= 1'b1;
    mwr(8'h00, 8'h02);
    rreg(8'h00, 8'h02);
    pulse(0);
    m_mode = 4;
    chk_outs();
    rreg(8'h01, 8'h01);
    rreg(8'h00, 8'h04);
    do_reset();
    pulse(0);
    m_mode = 4;
    chk_outs();
    rreg(8'h04, 8'h01);
    @(posedge clk);
    sense_lvl <= 1'b0;
    repeat (3) @(posedge clk);
    rreg(8'h05, 8'h01);
    finish_test();
  end
endmodule // hv_measure_switch_control_tb
